// ==== logic/esc_consts.vh ====
// constants shared by the statistics counter bank and its storage
`ifndef ESC_CONSTS_VH
`define ESC_CONSTS_VH

// counter geometry
`define ESC_CTR_W 32
`define ESC_IDX_W 5
`define ESC_NUM_CTR 19
`define ESC_ADDR_W 7
`define ESC_COLL_W 8
`define ESC_CNUM_W 5

// counter indices; dump byte offset is index times four
`define ESC_TX_GOOD 0
`define ESC_TX_MAXCOL 1
`define ESC_TX_LATECOL 2
`define ESC_TX_UNDERRUN 3
`define ESC_TX_LOST_CRS 4
`define ESC_TX_DEFERRED 5
`define ESC_TX_SINGLE_COL 6
`define ESC_TX_MULTI_COL 7
`define ESC_TX_TOTAL_COL 8
`define ESC_RX_GOOD 9
`define ESC_RX_CRC 10
`define ESC_RX_ALIGN 11
`define ESC_RX_RESOURCE 12
`define ESC_RX_OVERRUN 13
`define ESC_RX_COLLISION 14
`define ESC_RX_SHORT 15
`define ESC_FC_TX_PAUSE 16
`define ESC_FC_RX_PAUSE 17
`define ESC_FC_RX_UNSUP 18

// last index of a basic and of an extended dump
`define ESC_BASIC_LAST 5'h0F
`define ESC_EXT_LAST 5'h12

// low byte-address bits of a dumped word
`define ESC_WORD_LSB 2'h0

// reset and step values
`define ESC_ZERO_CTR 32'h00000000
`define ESC_ZERO_IDX 5'h00
`define ESC_ONE_IDX 5'h01
`define ESC_ZERO_COLL 8'h00
`define ESC_ONE_COLL 8'h01
`define ESC_ONE_CNUM 5'h01

// one-hot engine states
`define ESC_ST_IDLE 3'h1
`define ESC_ST_INC 3'h2
`define ESC_ST_DUMP 3'h4

`endif

// ==== logic/esc_mem.v ====
// storage for the nineteen statistics words, registered read port
`timescale 1ns/10ps
`include "esc_consts.vh"

module esc_mem (
  input wire clk,
  input wire rst,
  input wire we,
  input wire [`ESC_IDX_W-1:0] waddr,
  input wire [`ESC_CTR_W-1:0] wdata,
  input wire [`ESC_IDX_W-1:0] raddr,
  output reg [`ESC_CTR_W-1:0] rdata_q
);

  wire [`ESC_CTR_W-1:0] word_w [0:`ESC_NUM_CTR-1];

  // one flop word per counter so reset can clear them all at once
  genvar g;
  generate
    for (g = 0; g < `ESC_NUM_CTR; g = g + 1) begin : g_word
      reg [`ESC_CTR_W-1:0] word_q;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          word_q <= `ESC_ZERO_CTR;
        end else if (we && (waddr == g)) begin
          word_q <= wdata;
        end
      end
      assign word_w[g] = word_q;
    end
  endgenerate

  // read data registered; out-of-range address reads zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `ESC_ZERO_CTR;
    end else if (raddr < `ESC_NUM_CTR) begin
      rdata_q <= word_w[raddr];
    end else begin
      rdata_q <= `ESC_ZERO_CTR;
    end
  end

endmodule // esc_mem

// ==== logic/esc_stats.v ====
// statistics counter bank: frame event capture, increment engine, dump
`timescale 1ns/10ps
`include "esc_consts.vh"


module esc_stats (
  input wire clk,
  input wire rst,
  // transmit frame completion report
  input wire tx_done,
  input wire tx_good,
  input wire tx_maxcol,
  input wire tx_latecol,
  input wire tx_underrun,
  input wire tx_lost_crs,
  input wire tx_deferred,
  input wire [`ESC_CNUM_W-1:0] tx_coll_num,
  input wire tx_pause,
  // receive frame completion report
  input wire rx_done,
  input wire rx_good,
  input wire rx_crc_err,
  input wire rx_misaligned,
  input wire rx_short,
  input wire rx_no_resources,
  input wire rx_bad_status,
  input wire rx_lost,
  input wire rx_collision,
  input wire rx_pause,
  input wire rx_unsupported_ctl,
  // configuration from the configuration command
  input wire save_bad_en,
  input wire ext_stats_en,
  // command unit request
  input wire dump_cmd,
  input wire dump_clear,
  // snapshot write toward host memory
  input wire dump_wr_ready,
  output reg dump_wr_valid_q,
  output reg [`ESC_ADDR_W-1:0] dump_wr_addr_q,
  output reg [`ESC_CTR_W-1:0] dump_wr_data_q,
  output reg dump_done_q,
  output reg dump_busy_q
);

  localparam ST_IDLE = `ESC_ST_IDLE;
  localparam ST_INC = `ESC_ST_INC;
  localparam ST_DUMP = `ESC_ST_DUMP;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`ESC_NUM_CTR-1:0] pend_q;
  reg [`ESC_NUM_CTR-1:0] pend_d;
  reg [`ESC_NUM_CTR-1:0] pend_clr;
  reg [`ESC_COLL_W-1:0] coll_acc_q;
  reg [`ESC_COLL_W-1:0] coll_acc_d;
  reg [`ESC_COLL_W-1:0] amt_q;
  reg [`ESC_COLL_W-1:0] amt_d;
  reg [`ESC_IDX_W-1:0] inc_idx_q;
  reg [`ESC_IDX_W-1:0] inc_idx_d;
  reg [`ESC_IDX_W-1:0] pick_idx;
  reg ovr_run_q;
  reg dump_act_q;
  reg dump_act_d;
  reg dump_clr_q;
  reg dump_wlast_q;
  reg [`ESC_IDX_W-1:0] dump_idx_q;
  reg [`ESC_IDX_W-1:0] dump_idx_d;
  reg [`ESC_IDX_W-1:0] dump_last_q;
  reg [`ESC_IDX_W-1:0] mem_raddr;
  reg mem_we;
  reg [`ESC_IDX_W-1:0] mem_waddr;
  reg [`ESC_CTR_W-1:0] mem_wdata;
  reg wr_valid_d;
  reg wlast_d;
  wire [`ESC_CTR_W-1:0] mem_rdata;
  wire [`ESC_NUM_CTR-1:0] ev;
  wire [`ESC_CTR_W-1:0] inc_sum;
  wire wr_accept;
  wire tx_any_col;
  wire tx_multi_col;
  wire rx_ovr_first;

  // transmit events, sampled only on the frame completion strobe
  assign tx_any_col = (tx_coll_num != {`ESC_CNUM_W{1'b0}});
  assign tx_multi_col = (tx_coll_num > `ESC_ONE_CNUM);
  assign ev[`ESC_TX_GOOD] = tx_done & tx_good;
  assign ev[`ESC_TX_MAXCOL] = tx_done & tx_maxcol;
  assign ev[`ESC_TX_LATECOL] = tx_done & tx_latecol;
  assign ev[`ESC_TX_UNDERRUN] = tx_done & tx_underrun;
  assign ev[`ESC_TX_LOST_CRS] = tx_done & tx_lost_crs;
  assign ev[`ESC_TX_DEFERRED] = tx_done & tx_deferred;
  assign ev[`ESC_TX_SINGLE_COL] = tx_done & tx_good & tx_any_col &
                                  ~tx_multi_col;
  assign ev[`ESC_TX_MULTI_COL] = tx_done & tx_good & tx_multi_col;
  assign ev[`ESC_TX_TOTAL_COL] = tx_done & tx_any_col;
  assign ev[`ESC_FC_TX_PAUSE] = tx_done & tx_pause;

  // receive events; no gating by receive unit state on purpose
  assign ev[`ESC_RX_GOOD] = rx_done & rx_good;
  assign ev[`ESC_RX_CRC] = rx_done & rx_crc_err & ~rx_misaligned &
                           ~rx_short;
  assign ev[`ESC_RX_ALIGN] = rx_done & rx_misaligned & rx_crc_err &
                             ~rx_short;
  assign ev[`ESC_RX_SHORT] = rx_done & rx_short;
  assign ev[`ESC_RX_RESOURCE] = rx_done & rx_no_resources &
                                ~(save_bad_en & rx_bad_status);
  assign ev[`ESC_RX_OVERRUN] = rx_ovr_first;
  assign ev[`ESC_RX_COLLISION] = rx_done & rx_collision;
  assign ev[`ESC_FC_RX_PAUSE] = rx_done & rx_pause;
  assign ev[`ESC_FC_RX_UNSUP] = rx_done & rx_unsupported_ctl;

  // only the first frame of a lost run is counted; the run ends on the
  // next completed frame that was not lost
  assign rx_ovr_first = rx_done & rx_lost & ~ovr_run_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_run_q <= 1'b0;
    end else if (rx_done) begin
      ovr_run_q <= rx_lost;
    end
  end

  // lowest pending index wins; order does not matter for correctness
  integer i;
  always @* begin
    pick_idx = `ESC_ZERO_IDX;
    for (i = `ESC_NUM_CTR - 1; i >= 0; i = i - 1) begin
      if (pend_q[i]) begin
        pick_idx = i[`ESC_IDX_W-1:0];
      end
    end
  end

  // the adder wraps naturally at full scale
  assign inc_sum = mem_rdata + {{(`ESC_CTR_W-`ESC_COLL_W){1'b0}}, amt_q};

  assign wr_accept = dump_wr_valid_q & dump_wr_ready;

  // engine: increments take priority, dump words fill the gaps; each word
  // is read and written in one pass so a dumped value is never torn
  always @* begin
    state_d = state_q;
    pend_clr = {`ESC_NUM_CTR{1'b0}};
    inc_idx_d = inc_idx_q;
    amt_d = amt_q;
    mem_raddr = dump_idx_q;
    mem_we = 1'b0;
    mem_waddr = inc_idx_q;
    mem_wdata = inc_sum;
    dump_idx_d = dump_idx_q;
    dump_act_d = dump_act_q;
    wr_valid_d = dump_wr_valid_q & ~dump_wr_ready;
    wlast_d = dump_wlast_q;
    case (state_q)
      ST_IDLE: begin
        if (pend_q != {`ESC_NUM_CTR{1'b0}}) begin
          mem_raddr = pick_idx;
          inc_idx_d = pick_idx;
          pend_clr[pick_idx] = 1'b1;
          if (pick_idx == `ESC_TX_TOTAL_COL) begin
            amt_d = coll_acc_q;
          end else begin
            amt_d = `ESC_ONE_COLL;
          end
          state_d = ST_INC;
        end else if (dump_act_q && !dump_wr_valid_q) begin
          mem_raddr = dump_idx_q;
          state_d = ST_DUMP;
        end
      end
      ST_INC: begin
        mem_we = 1'b1;
        mem_waddr = inc_idx_q;
        mem_wdata = inc_sum;
        state_d = ST_IDLE;
      end
      ST_DUMP: begin
        // clear only ever writes zero; there is no preset path
        mem_we = dump_clr_q;
        mem_waddr = dump_idx_q;
        mem_wdata = `ESC_ZERO_CTR;
        wr_valid_d = 1'b1;
        wlast_d = (dump_idx_q == dump_last_q);
        dump_idx_d = dump_idx_q + `ESC_ONE_IDX;
        if (dump_idx_q == dump_last_q) begin
          dump_act_d = 1'b0;
        end
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // new events set pending bits; a set in the clearing cycle wins
  always @* begin
    pend_d = (pend_q & ~pend_clr) | ev;
    if (pend_clr[`ESC_TX_TOTAL_COL]) begin
      coll_acc_d = `ESC_ZERO_COLL;
    end else begin
      coll_acc_d = coll_acc_q;
    end
    if (tx_done) begin
      coll_acc_d = coll_acc_d +
                   {{(`ESC_COLL_W-`ESC_CNUM_W){1'b0}}, tx_coll_num};
    end
  end

  // engine and pending state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      pend_q <= {`ESC_NUM_CTR{1'b0}};
      coll_acc_q <= `ESC_ZERO_COLL;
      amt_q <= `ESC_ZERO_COLL;
      inc_idx_q <= `ESC_ZERO_IDX;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      coll_acc_q <= coll_acc_d;
      amt_q <= amt_d;
      inc_idx_q <= inc_idx_d;
    end
  end

  // dump sequencer; a command while a dump is running is ignored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dump_act_q <= 1'b0;
      dump_clr_q <= 1'b0;
      dump_idx_q <= `ESC_ZERO_IDX;
      dump_last_q <= `ESC_BASIC_LAST;
    end else if (dump_cmd && !dump_busy_q && !dump_act_q) begin
      dump_act_q <= 1'b1;
      dump_clr_q <= dump_clear;
      dump_idx_q <= `ESC_ZERO_IDX;
      dump_last_q <= ext_stats_en ? `ESC_EXT_LAST : `ESC_BASIC_LAST;
    end else begin
      dump_act_q <= dump_act_d;
      dump_idx_q <= dump_idx_d;
    end
  end

  // snapshot word toward host memory, held until accepted
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dump_wr_valid_q <= 1'b0;
      dump_wr_addr_q <= {`ESC_ADDR_W{1'b0}};
      dump_wr_data_q <= `ESC_ZERO_CTR;
      dump_wlast_q <= 1'b0;
      dump_done_q <= 1'b0;
      dump_busy_q <= 1'b0;
    end else begin
      dump_wr_valid_q <= wr_valid_d;
      dump_wlast_q <= wlast_d;
      if (state_q == ST_DUMP) begin
        dump_wr_addr_q <= {dump_idx_q, `ESC_WORD_LSB};
        dump_wr_data_q <= mem_rdata;
      end
      dump_done_q <= wr_accept & dump_wlast_q;
      // busy covers the command cycle too so a second command is refused
      dump_busy_q <= (dump_cmd & ~dump_busy_q) | dump_act_d |
                     (dump_act_q & ~(state_q == ST_DUMP & ~dump_act_d)) |
                     wr_valid_d;
    end
  end

  // counter storage, nineteen words of full width
  esc_mem u_mem (
    .clk(clk),
    .rst(rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

endmodule // esc_stats

// ==== testbench/esc_stats_properties.sv ====
// dump-port assertions for the statistics counter bank
`timescale 1ns/10ps
module esc_stats_properties (
  input wire clk,
  input wire rst,
  input wire ext_stats_en,
  input wire dump_cmd,
  input wire dump_wr_ready,
  input wire dump_wr_valid_q,
  input wire [6:0] dump_wr_addr_q,
  input wire [31:0] dump_wr_data_q,
  input wire dump_done_q,
  input wire dump_busy_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg [6:0] acc_q;
  wire acc = dump_wr_valid_q && dump_wr_ready;
  wire start = dump_cmd && !dump_busy_q;
  wire [6:0] last = ext_stats_en ? 7'h48 : 7'h3C;
  // last accepted offset; 7C wraps so the first word must be zero
  always @(posedge clk or posedge rst) begin
    if (rst) acc_q <= 7'h7C;
    else if (start) acc_q <= 7'h7C;
    else if (acc) acc_q <= dump_wr_addr_q;
  end
  hold_word_a:
    assert property (dump_wr_valid_q && !dump_wr_ready |=> dump_wr_valid_q
      && $stable(dump_wr_addr_q) && $stable(dump_wr_data_q))
    else $error("dump word changed before accept");
  word_align_a:
    assert property (dump_wr_valid_q |-> dump_wr_addr_q[1:0] == 2'h0)
    else $error("dump offset not word aligned");
  dump_len_a:
    assert property (dump_wr_valid_q |-> dump_wr_addr_q <= last)
    else $error("dump offset beyond last counter");
  next_addr_a:
    assert property ($rose(dump_wr_valid_q) |-> dump_wr_addr_q == acc_q + 7'h04)
    else $error("dump offset out of sequence");
  busy_start_a:
    assert property (start |=> dump_busy_q)
    else $error("busy missing after dump command");
  first_word_a:
    assert property (start |-> ##[3:60] dump_wr_valid_q)
    else $error("no dump word after command");
  done_last_a:
    assert property (acc && dump_wr_addr_q == last |=> dump_done_q)
    else $error("done missing after last word");
  done_early_a:
    assert property (acc && dump_wr_addr_q != last |=> !dump_done_q)
    else $error("done before last word");
  one_out_a:
    assert property (dump_wr_valid_q |-> dump_busy_q)
    else $error("dump word outside busy");
  cover property (acc && dump_wr_addr_q == 7'h48);
  cover property (acc && dump_wr_addr_q == 7'h3C && !ext_stats_en);
  cover property ((dump_wr_valid_q && !dump_wr_ready) [*3]);
endmodule // esc_stats_properties

bind esc_stats esc_stats_properties u_props (.clk(clk), .rst(rst),
  .ext_stats_en(ext_stats_en), .dump_cmd(dump_cmd),
  .dump_wr_ready(dump_wr_ready), .dump_wr_valid_q(dump_wr_valid_q),
  .dump_wr_addr_q(dump_wr_addr_q), .dump_wr_data_q(dump_wr_data_q),
  .dump_done_q(dump_done_q), .dump_busy_q(dump_busy_q));

// ==== testbench/esc_host_sink.sv ====
// memory-side model that stores dumped statistics words
`timescale 1ns/10ps
module esc_host_sink (
  input wire clk,
  input wire rst,
  input wire slow,
  input wire valid,
  input wire [6:0] addr,
  input wire [31:0] data,
  output reg ready_q,
  output reg [7:0] n_words_q
);
  reg [31:0] mem [0:31];
  reg [2:0] wait_q;
  // ready is registered; slow mode stalls to exercise the hold rule
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b0;
      wait_q <= 3'h0;
      n_words_q <= 8'h00;
    end else if (valid && ready_q) begin
      ready_q <= 1'b0;
      wait_q <= 3'h0;
      n_words_q <= n_words_q + 8'h01;
    end else if (valid) begin
      wait_q <= wait_q + 3'h1;
      ready_q <= slow ? (wait_q == 3'h4) : 1'b1;
    end
  end
  // snapshot lands at its byte offset in host memory
  always @(posedge clk) begin
    if (valid && ready_q) mem[addr[6:2]] <= data;
  end
endmodule // esc_host_sink

// ==== testbench/tb_ethernet_statistics_counters.sv ====
// self-checking bench for the statistics counter bank
`timescale 1ns/10ps
module tb_ethernet_statistics_counters;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg tx_done = 1'b0;
  reg rx_done = 1'b0;
  reg [5:0] txf = 6'h00;
  reg tx_pause = 1'b0;
  reg [4:0] coll = 5'h00;
  reg [9:0] rxf = 10'h000;
  reg save_bad = 1'b0;
  reg ext = 1'b0;
  reg dcmd = 1'b0;
  reg dclr = 1'b0;
  reg slow = 1'b0;
  wire rdy, vld, done, busy;
  wire [6:0] addr;
  wire [31:0] data;
  wire [7:0] n_words;
  reg [31:0] exp_v [0:18];
  integer err_count = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer k;
  always #2.5 clk = ~clk;
  esc_stats u_dut (.clk(clk), .rst(rst), .tx_done(tx_done),
    .tx_good(txf[5]), .tx_maxcol(txf[4]), .tx_latecol(txf[3]),
    .tx_underrun(txf[2]), .tx_lost_crs(txf[1]), .tx_deferred(txf[0]),
    .tx_coll_num(coll), .tx_pause(tx_pause), .rx_done(rx_done),
    .rx_good(rxf[9]), .rx_crc_err(rxf[8]), .rx_misaligned(rxf[7]),
    .rx_short(rxf[6]), .rx_no_resources(rxf[5]), .rx_bad_status(rxf[4]),
    .rx_lost(rxf[3]), .rx_collision(rxf[2]), .rx_pause(rxf[1]),
    .rx_unsupported_ctl(rxf[0]), .save_bad_en(save_bad),
    .ext_stats_en(ext), .dump_cmd(dcmd), .dump_clear(dclr),
    .dump_wr_ready(rdy), .dump_wr_valid_q(vld), .dump_wr_addr_q(addr),
    .dump_wr_data_q(data), .dump_done_q(done), .dump_busy_q(busy));
  esc_host_sink u_sink (.clk(clk), .rst(rst), .slow(slow), .valid(vld),
    .addr(addr), .data(data), .ready_q(rdy), .n_words_q(n_words));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] want);
    begin
      n_checks = n_checks + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask
  // one frame report; 40 idle cycles keep same-counter events apart
  task rx_ev(input [9:0] f);
    begin
      rxf <= f;
      rx_done <= 1'b1;
      @(posedge clk);
      rxf <= 10'h000;
      rx_done <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  task tx_ev(input [5:0] f, input p, input [4:0] n);
    begin
      txf <= f;
      tx_pause <= p;
      coll <= n;
      tx_done <= 1'b1;
      @(posedge clk);
      txf <= 6'h00;
      tx_pause <= 1'b0;
      tx_done <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  // dump, then compare every word; undumped words must stay untouched
  task dump(input e, input c, input s, input rf);
    integer i;
    reg [7:0] base;
    begin
      for (i = 0; i < 19; i = i + 1) u_sink.mem[i] = ~exp_v[i];
      base = n_words;
      ext <= e;
      dclr <= c;
      slow <= s;
      @(posedge clk);
      dcmd <= 1'b1;
      @(posedge clk);
      dcmd <= 1'b0;
      if (rf) begin
        repeat (3) @(posedge clk);
        dcmd <= 1'b1; // ignored while busy
        @(posedge clk);
        dcmd <= 1'b0;
      end
      i = 0;
      while (done !== 1'b1 && i < 500) begin
        @(negedge clk);
        i = i + 1;
      end
      repeat (60) @(posedge clk);
      chk({24'h0, n_words - base}, e ? 32'h13 : 32'h10);
      for (i = 0; i < 19; i = i + 1)
        chk(u_sink.mem[i], (i < 16 || e) ? exp_v[i] : ~exp_v[i]);
      if (c) for (i = 0; i < 19; i = i + 1) exp_v[i] = 32'h0;
    end
  endtask
  task t_reset;
    begin
      dump(1'b0, 1'b0, 1'b0, 1'b0);
      $display("test reset done");
    end
  endtask
  task t_rx_err;
    begin
      rx_ev(10'h180);
      rx_ev(10'h100);
      rx_ev(10'h1C0);
      exp_v[11] = 32'h1;
      exp_v[10] = 32'h1;
      exp_v[15] = 32'h1;
      dump(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test rx errors done");
    end
  endtask
  task t_res;
    begin
      save_bad <= 1'b1;
      rx_ev(10'h030);
      rx_ev(10'h020);
      save_bad <= 1'b0;
      rx_ev(10'h030);
      exp_v[12] = 32'h2;
      dump(1'b1, 1'b0, 1'b1, 1'b0);
      $display("test resource done");
    end
  endtask
  task t_ovr;
    begin
      for (k = 0; k < 3; k = k + 1) rx_ev(10'h008);
      rx_ev(10'h200);
      rx_ev(10'h008);
      exp_v[13] = 32'h2;
      exp_v[9] = 32'h1;
      dump(1'b1, 1'b0, 1'b0, 1'b1);
      $display("test overrun done");
    end
  endtask
  task t_multi;
    begin
      rx_ev(10'h207);
      tx_ev(6'h20, 1'b1, 5'h01);
      tx_ev(6'h1F, 1'b0, 5'h03);
      exp_v[9] = 32'h2;
      exp_v[14] = 32'h1;
      exp_v[17] = 32'h1;
      exp_v[18] = 32'h1;
      exp_v[16] = 32'h1;
      for (k = 0; k < 7; k = k + 1) exp_v[k] = 32'h1;
      exp_v[8] = 32'h4;
      dump(1'b1, 1'b1, 1'b0, 1'b0);
      dump(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test multi and clear done");
    end
  endtask
  // no preset path exists, so full scale is planted in the storage word;
  // one more event must read it, add one and land on zero
  task t_wrap;
    begin
      u_dut.u_mem.g_word[16].word_q = 32'hFFFFFFFF;
      tx_ev(6'h00, 1'b1, 5'h00);
      exp_v[16] = 32'h0;
      dump(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test wrap done");
    end
  endtask
  // hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  initial begin
    for (k = 0; k < 19; k = k + 1) exp_v[k] = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_rx_err;
    t_res;
    t_ovr;
    t_multi;
    t_wrap;
    end_sim;
  end
endmodule // tb_ethernet_statistics_counters
